// ---- rtl/ptr_unit_pkg.sv ----
package ptr_unit_pkg;

  localparam int          PTR_COUNT  = 3;
  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 8;
  localparam int          MEM_DEPTH  = 4096;
  localparam int          APB_AW     = 8;

  // pseudo-register block of each pointer, counted down from its plain port
  localparam logic [11:0] PORT_BASE [PTR_COUNT] = '{12'hFEF, 12'hFE7, 12'hFDF};

  typedef enum logic [2:0] {
    SLOT_PLAIN   = 3'h0,
    SLOT_POST_INCREMENT_PORT = 3'h1,
    SLOT_POST_DECREMENT_PORT = 3'h2,
    SLOT_PRE_INCREMENT_PORT  = 3'h3,
    SLOT_INDEXED = 3'h4,
    SLOT_HIGH    = 3'h5,
    SLOT_LOW     = 3'h6
  } slot_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RESP = 1'b1
  } state_t;

  typedef enum logic [1:0] {
    SRC_RAM  = 2'h0,
    SRC_ZERO = 2'h1,
    SRC_BYTE = 2'h2
  } src_t;

  localparam logic [7:0]  OFS_PTR0 = 8'h00;
  localparam logic [7:0]  OFS_PTR1 = 8'h04;
  localparam logic [7:0]  OFS_PTR2 = 8'h08;
  localparam logic [7:0]  OFS_ACC  = 8'h0C;
  localparam logic [7:0]  OFS_STAT = 8'h10;

  localparam logic [11:0] PTR_RST       = 12'h000;
  localparam logic [7:0]  ACC_RST       = 8'h00;
  localparam int          STAT_BUSY_BIT = 16;
  localparam logic [11:0] ONE_12        = 12'h001;

endpackage : ptr_unit_pkg

// ---- rtl/data_store.sv ----
`timescale 1ns/1ps
module data_store
  import ptr_unit_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              en,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata
);

  // no reset on the array: contents are undefined until written
  logic [DATA_W-1:0] mem [MEM_DEPTH];

  always_ff @(posedge pclk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 8'h00;
    end else if (en && !we) begin
      rdata <= mem[addr];
    end
  end

endmodule : data_store

// ---- rtl/indirect_address_pointer_unit.sv ----
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - three independent 12-bit pointers, each a high and a low byte.
// - the plain port reads or writes the location the pointer holds.
// - any operand address may name an indirect port.
// - indirect read of a port location returns zero and sets zero flag.
// - indirect write to a port location does nothing; flags untouched.
// - plain port access leaves the pointer unchanged.
// - post-decrement uses current pointer, then decrements it by one.
// - post-increment uses current pointer, then increments it by one.
// - pre-increment increments first and uses the new value.
// - indexed port adds signed accumulator; pointer and accumulator kept.
// - automatic pointer updates never change any status flag.
// - updates act on all 12 bits, carrying and borrowing between bytes.
// - a write to the pointer's own byte beats its pending auto update.
module indirect_address_pointer_unit
  import ptr_unit_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              op_valid,
  input  wire logic              op_write,
  input  wire logic [ADDR_W-1:0] op_addr,
  input  wire logic [DATA_W-1:0] op_wdata,
  output logic                   op_done,
  output logic      [DATA_W-1:0] op_rdata,
  output logic                   op_zero,
  output logic                   flag_update
);

  logic [ADDR_W-1:0] ptr_reg [PTR_COUNT];
  logic [DATA_W-1:0] acc_reg;
  state_t            state_reg;
  src_t              src_reg;
  logic [DATA_W-1:0] byte_reg;
  logic              write_reg;
  logic [1:0]        sel_reg;
  logic [ADDR_W-1:0] last_ea_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic [31:0]       prdata_reg;
  logic              op_done_reg;
  logic [DATA_W-1:0] op_rdata_reg;
  logic              op_zero_reg;
  logic              flag_update_reg;

  logic [5:0]        op_map;
  logic [5:0]        ea_map;
  logic              op_ind;
  logic [1:0]        op_idx;
  slot_t             op_slot;
  logic [ADDR_W-1:0] cur_ptr;
  logic [ADDR_W-1:0] sext_acc;
  logic [ADDR_W-1:0] ea;
  logic [ADDR_W-1:0] upd_val;
  logic              upd_kind;
  logic              ea_port;
  logic              ea_ptrbyte;
  logic [1:0]        ea_idx;
  logic              fire;
  logic              self_wr;
  logic              upd_en;
  logic              ptr_wr;
  logic              apb_setup;
  logic              apb_commit;
  logic              apb_ptr_wr;
  logic [1:0]        apb_idx;
  logic              apb_mapped;
  logic [31:0]       apb_rmux;
  logic [DATA_W-1:0] ram_rdata;
  logic [DATA_W-1:0] resp_data;

  // hit, pointer index, slot: where an address falls among the pseudo-registers
  function automatic logic [5:0] map_addr(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    logic [5:0]        r;
    r = 6'h00;
    for (int n = 0; n < PTR_COUNT; n++) begin
      d = PORT_BASE[n] - a;
      if (d <= 12'(SLOT_LOW)) begin
        r = {1'b1, 2'(n), d[2:0]};
      end
    end
    return r;
  endfunction : map_addr

  assign op_map   = map_addr(op_addr);
  assign op_ind   = op_map[5] && (op_map[2:0] <= SLOT_INDEXED);
  assign op_idx   = op_map[4:3];
  assign op_slot  = slot_t'(op_map[2:0]);
  assign cur_ptr  = ptr_reg[op_idx];
  assign sext_acc = {{(ADDR_W-DATA_W){acc_reg[DATA_W-1]}}, acc_reg};

  always_comb begin
    ea       = op_addr;
    upd_val  = cur_ptr;
    upd_kind = 1'b0;
    if (op_ind) begin
      case (op_slot)
        SLOT_PLAIN: begin
          ea = cur_ptr;
        end
        SLOT_POST_INCREMENT_PORT: begin
          ea       = cur_ptr;
          upd_val  = cur_ptr + ONE_12;
          upd_kind = 1'b1;
        end
        SLOT_POST_DECREMENT_PORT: begin
          ea       = cur_ptr;
          upd_val  = cur_ptr - ONE_12;
          upd_kind = 1'b1;
        end
        SLOT_PRE_INCREMENT_PORT: begin
          ea       = cur_ptr + ONE_12;
          upd_val  = cur_ptr + ONE_12;
          upd_kind = 1'b1;
        end
        SLOT_INDEXED: begin
          ea = cur_ptr + sext_acc;
        end
        default: begin
          ea = op_addr;
        end
      endcase
    end
  end

  assign ea_map     = map_addr(ea);
  assign ea_port    = ea_map[5] && (ea_map[2:0] <= SLOT_INDEXED);
  assign ea_ptrbyte = ea_map[5] && (ea_map[2:0] >= SLOT_HIGH);
  assign ea_idx     = ea_map[4:3];

  // a held request is taken once; an apb pointer write delays it a cycle
  assign fire    = op_valid && (state_reg == ST_IDLE) && !op_done_reg && !apb_ptr_wr;
  assign ptr_wr  = fire && op_write && ea_ptrbyte;
  assign self_wr = ptr_wr && (ea_idx == op_idx);
  assign upd_en  = fire && op_ind && upd_kind && !self_wr;

  for (genvar g = 0; g < PTR_COUNT; g++) begin : g_ptr
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ptr_reg[g] <= PTR_RST;
      end else if (ptr_wr && (ea_idx == 2'(g))) begin
        if (ea_map[2:0] == SLOT_HIGH) begin
          ptr_reg[g] <= {op_wdata[3:0], ptr_reg[g][7:0]};
        end else begin
          ptr_reg[g] <= {ptr_reg[g][11:8], op_wdata};
        end
      end else if (upd_en && (op_idx == 2'(g))) begin
        ptr_reg[g] <= upd_val;
      end else if (apb_ptr_wr && (apb_idx == 2'(g))) begin
        ptr_reg[g] <= pwdata[ADDR_W-1:0];
      end
    end
  end

  data_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (fire && !ea_map[5]),
    .we      (op_write),
    .addr    (ea),
    .wdata   (op_wdata),
    .rdata   (ram_rdata)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (fire) begin
            state_reg <= ST_RESP;
          end
        end
        ST_RESP: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg     <= SRC_RAM;
      byte_reg    <= 8'h00;
      write_reg   <= 1'b0;
      sel_reg     <= 2'h0;
      last_ea_reg <= 12'h000;
    end else if (fire) begin
      write_reg   <= op_write;
      sel_reg     <= op_idx;
      last_ea_reg <= ea;
      if (ea_port) begin
        src_reg <= SRC_ZERO;
      end else if (ea_ptrbyte) begin
        src_reg <= SRC_BYTE;
      end else begin
        src_reg <= SRC_RAM;
      end
      if (ea_map[2:0] == SLOT_HIGH) begin
        byte_reg <= {4'h0, ptr_reg[ea_idx][11:8]};
      end else begin
        byte_reg <= ptr_reg[ea_idx][7:0];
      end
    end
  end

  always_comb begin
    case (src_reg)
      SRC_RAM:  resp_data = ram_rdata;
      SRC_BYTE: resp_data = byte_reg;
      default:  resp_data = 8'h00;
    endcase
  end

  // writes leave flags alone; flags follow data only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_done_reg     <= 1'b0;
      op_rdata_reg    <= 8'h00;
      op_zero_reg     <= 1'b0;
      flag_update_reg <= 1'b0;
    end else if (state_reg == ST_RESP) begin
      op_done_reg     <= 1'b1;
      op_rdata_reg    <= write_reg ? 8'h00 : resp_data;
      op_zero_reg     <= !write_reg && (resp_data == 8'h00);
      flag_update_reg <= !write_reg;
    end else begin
      op_done_reg     <= 1'b0;
      flag_update_reg <= 1'b0;
    end
  end

  // apb: zero wait states, answer prepared in the setup cycle
  assign apb_setup  = psel && !penable;
  assign apb_commit = psel && penable && pready_reg && pwrite;
  assign apb_idx    = paddr[3:2];
  assign apb_ptr_wr = apb_commit && ((paddr == OFS_PTR0) || (paddr == OFS_PTR1) || (paddr == OFS_PTR2));

  always_comb begin
    apb_mapped = 1'b1;
    apb_rmux   = 32'h0000_0000;
    case (paddr)
      OFS_PTR0: apb_rmux[ADDR_W-1:0] = ptr_reg[0];
      OFS_PTR1: apb_rmux[ADDR_W-1:0] = ptr_reg[1];
      OFS_PTR2: apb_rmux[ADDR_W-1:0] = ptr_reg[2];
      OFS_ACC:  apb_rmux[DATA_W-1:0] = acc_reg;
      OFS_STAT: begin
        apb_rmux[ADDR_W-1:0]    = last_ea_reg;
        apb_rmux[STAT_BUSY_BIT] = (state_reg == ST_RESP);
      end
      default:  apb_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup && !apb_mapped;
      prdata_reg  <= (apb_setup && !pwrite) ? apb_rmux : 32'h0000_0000;
    end
  end

  // accumulator kept here so the indexed port has an offset source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= ACC_RST;
    end else if (apb_commit && (paddr == OFS_ACC)) begin
      acc_reg <= pwdata[DATA_W-1:0];
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign op_done     = op_done_reg;
  assign op_rdata    = op_rdata_reg;
  assign op_zero     = op_zero_reg;
  assign flag_update = flag_update_reg;

  logic [ADDR_W-1:0] track_ptr;
  assign track_ptr = ptr_reg[sel_reg];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PLAIN_HOLD: assert property (
    fire && op_ind && op_slot == SLOT_PLAIN && !self_wr |=> track_ptr == $past(cur_ptr) && last_ea_reg == track_ptr)
    else $error("plain port moved its pointer");
  AST_POST_DECREMENT_PORT: assert property (
    fire && op_ind && op_slot == SLOT_POST_DECREMENT_PORT && !self_wr
      |=> last_ea_reg == $past(cur_ptr) && track_ptr == $past(cur_ptr) - ONE_12)
    else $error("post-decrement wrong");
  AST_POST_INCREMENT_PORT: assert property (
    fire && op_ind && op_slot == SLOT_POST_INCREMENT_PORT && !self_wr
      |=> last_ea_reg == $past(cur_ptr) && track_ptr == $past(cur_ptr) + ONE_12)
    else $error("post-increment wrong");
  AST_PRE_INCREMENT_PORT: assert property (
    fire && op_ind && op_slot == SLOT_PRE_INCREMENT_PORT && !self_wr
      |=> last_ea_reg == $past(cur_ptr) + ONE_12 && track_ptr == last_ea_reg)
    else $error("pre-increment wrong");
  AST_INDEXED: assert property (
    fire && op_ind && op_slot == SLOT_INDEXED && !self_wr
      |=> last_ea_reg == $past(cur_ptr) + $past(sext_acc) && track_ptr == $past(cur_ptr))
    else $error("indexed address wrong");
  AST_PORT_READ_ZERO: assert property (
    fire && !op_write && ea_port |-> ##2 op_done && op_rdata == 8'h00 && op_zero && flag_update)
    else $error("port read not zero");
  AST_PORT_WRITE_NOP: assert property (
    fire && op_write && ea_port |-> ##2 op_done && !flag_update)
    else $error("port write touched flags");
  AST_FLAG_FROM_DATA: assert property (
    op_done |-> op_zero == (flag_update && op_rdata == 8'h00))
    else $error("flag not tied to data");
  AST_SELF_WRITE: assert property (
    self_wr |=> track_ptr == (($past(ea_map[2:0]) == SLOT_HIGH) ? {$past(op_wdata[3:0]), $past(cur_ptr[7:0])}
                                                                 : {$past(cur_ptr[11:8]), $past(op_wdata)}))
    else $error("auto update beat byte write");
  AST_DONE_LATENCY: assert property (
    fire |=> !fire ##1 op_done)
    else $error("access not answered in two cycles");

  COV_POST_INCREMENT_PORT_WRAP: cover property (fire && op_ind && op_slot == SLOT_POST_INCREMENT_PORT && cur_ptr[7:0] == 8'hFF);
  COV_PORT_READ: cover property (fire && !op_write && ea_port);
  COV_SELF_WRITE: cover property (self_wr);
  COV_NEG_INDEX: cover property (fire && op_slot == SLOT_INDEXED && op_ind && acc_reg[7]);

endmodule : indirect_address_pointer_unit

// ---- test/core_model.sv ----
`timescale 1ns/1ps
module core_model
  import ptr_unit_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              go,
  input  wire logic              go_write,
  input  wire logic [ADDR_W-1:0] go_addr,
  input  wire logic [DATA_W-1:0] go_wdata,
  input  wire logic [3:0]        go_delay,
  input  wire logic              op_done,
  input  wire logic [DATA_W-1:0] op_rdata,
  input  wire logic              op_zero,
  input  wire logic              flag_update,
  output logic                   op_valid,
  output logic                   op_write,
  output logic      [ADDR_W-1:0] op_addr,
  output logic      [DATA_W-1:0] op_wdata,
  output logic                   busy,
  output logic      [DATA_W-1:0] res_rdata,
  output logic                   res_zero,
  output logic                   res_flag
);
  logic [3:0] wait_reg;

  // request held until op_done seen; lines scrambled once released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_valid  <= 1'b0;
      op_write  <= 1'b0;
      op_addr   <= 12'hA5A;
      op_wdata  <= 8'h5A;
      busy      <= 1'b0;
      wait_reg  <= 4'h0;
      res_rdata <= 8'h00;
      res_zero  <= 1'b0;
      res_flag  <= 1'b0;
    end else if (go && !busy) begin
      busy     <= 1'b1;
      wait_reg <= go_delay;
      op_write <= go_write;
      op_addr  <= go_addr;
      op_wdata <= go_wdata;
    end else if (busy && !op_valid) begin
      if (wait_reg == 4'h0) begin
        op_valid <= 1'b1;
      end else begin
        wait_reg <= wait_reg - 4'h1;
      end
    end else if (op_valid && op_done) begin
      op_valid  <= 1'b0;
      busy      <= 1'b0;
      op_write  <= ~op_write;
      op_addr   <= ~op_addr;
      op_wdata  <= ~op_wdata;
      res_rdata <= op_rdata;
      res_zero  <= op_zero;
      res_flag  <= flag_update;
    end
  end
endmodule : core_model

// ---- test/test_indirect_address_pointer_unit.sv ----
`timescale 1ns/1ps
module test_indirect_address_pointer_unit
  import ptr_unit_pkg::*;
;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd, seed = 32'h0000002D;
  logic              pready, pslverr, op_valid, op_write, op_done, op_zero, flag_update, er;
  logic [ADDR_W-1:0] op_addr, go_addr = '0;
  logic [DATA_W-1:0] op_wdata, op_rdata, go_wdata = '0, res_rdata, acc = '0;
  logic              go = 0, go_write = 0, busy, res_zero, res_flag;
  logic [3:0]        go_delay = '0;
  int                fail_count = 0, total_checks = 0, cycles = 0;

  always #12.5 pclk = ~pclk;

  indirect_address_pointer_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op_write(op_write), .op_addr(op_addr), .op_wdata(op_wdata), .op_done(op_done),
    .op_rdata(op_rdata), .op_zero(op_zero), .flag_update(flag_update));

  core_model i_core (.pclk(pclk), .presetn(presetn), .go(go), .go_write(go_write), .go_addr(go_addr),
    .go_wdata(go_wdata), .go_delay(go_delay), .op_done(op_done), .op_rdata(op_rdata), .op_zero(op_zero),
    .flag_update(flag_update), .op_valid(op_valid), .op_write(op_write), .op_addr(op_addr),
    .op_wdata(op_wdata), .busy(busy), .res_rdata(res_rdata), .res_zero(res_zero), .res_flag(res_flag));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [11:0] eff(slot_t s, logic [11:0] p);
    if (s == SLOT_PRE_INCREMENT_PORT) return p + ONE_12;
    if (s == SLOT_INDEXED) return p + {{4{acc[7]}}, acc};
    return p;
  endfunction : eff

  function automatic logic [11:0] nxt(slot_t s, logic [11:0] p);
    if (s == SLOT_POST_DECREMENT_PORT) return p - ONE_12;
    if (s == SLOT_PLAIN || s == SLOT_INDEXED) return p;
    return p + ONE_12;
  endfunction : nxt

  task automatic complete_run();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // delay before the request varies, so the core is prompt or slow
  task automatic core(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    go       <= 1'b1;
    go_write <= w;
    go_addr  <= a;
    go_wdata <= d;
    go_delay <= 4'(xs() % 3);
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy !== 1'b0 && n < 30) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 30) begin
      fail_count++;
    end
  endtask : core

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    int n;
    slot_t s;
    logic [11:0] p, ea, pa;
    logic [7:0] d;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(er), 32'h1);
    // random base, index and pointer; each of the five port slots (0 to 4) taken in turn
    for (int i = 0; i < 40; i++) begin
      n = int'(xs() % 3);
      s = slot_t'(i % 5);
      p = 12'(xs() % 32'hE00) + 12'h100;
      acc = 8'(xs());
      d = (i % 7 == 0) ? 8'h00 : 8'(xs());
      apb(1'b1, OFS_ACC, 32'(acc));
      apb(1'b1, 8'(4 * n), 32'(p));
      ea = eff(s, p);
      core(1'b1, ea, d);
      core(1'b0, PORT_BASE[n] - 12'(s), 8'h00);
      chk(32'(res_rdata), 32'(d));
      chk(32'(res_zero), 32'(d == 8'h00));
      chk(32'(res_flag), 32'h1);
      apb(1'b0, 8'(4 * n), 32'h0);
      chk(rd, 32'(nxt(s, p)));
      apb(1'b0, OFS_ACC, 32'h0);
      chk(rd, 32'(acc));
      apb(1'b0, OFS_STAT, 32'h0);
      chk(32'(rd[11:0]), 32'(ea));
    end
    // carry, borrow and wrap at the 12-bit edges
    for (int k = 0; k < 5; k++) begin
      case (k)
        0: begin p = 12'h0FF; s = SLOT_POST_INCREMENT_PORT; end
        1: begin p = 12'h100; s = SLOT_POST_DECREMENT_PORT; end
        2: begin p = 12'h000; s = SLOT_POST_DECREMENT_PORT; end
        3: begin p = 12'hFFF; s = SLOT_PRE_INCREMENT_PORT; end
        default: begin p = 12'h001; s = SLOT_POST_DECREMENT_PORT; end
      endcase
      apb(1'b1, 8'(4 * (k % 3)), 32'(p));
      core(1'b1, PORT_BASE[k % 3] - 12'(s), 8'h5A);
      chk(32'(res_flag), 32'h0);
      apb(1'b0, 8'(4 * (k % 3)), 32'h0);
      chk(rd, 32'(nxt(s, p)));
      core(1'b0, eff(s, p), 8'h00);
      chk(32'(res_rdata), 32'h5A);
    end
    // pointer aimed at a port location
    apb(1'b1, OFS_PTR0, 32'(PORT_BASE[1]));
    core(1'b0, PORT_BASE[0], 8'h00);
    chk({res_rdata, 7'h0, res_zero, 7'h0, res_flag}, 32'h00000101);
    core(1'b1, PORT_BASE[0] - 12'h1, 8'h77);
    chk(32'(res_flag), 32'h0);
    // own byte, then another pointer's low byte, written through an updating port
    apb(1'b1, OFS_PTR0, 32'(PORT_BASE[0] - 12'h5));
    pa = PORT_BASE[0] - 12'h5;
    core(1'b1, PORT_BASE[0] - 12'h1, 8'h05);
    apb(1'b0, OFS_PTR0, 32'h0);
    chk(rd, {20'h0, 4'h5, pa[7:0]});
    apb(1'b1, OFS_PTR1, 32'h123);
    apb(1'b1, OFS_PTR0, 32'(PORT_BASE[1] - 12'h6));
    core(1'b1, PORT_BASE[0] - 12'h1, 8'h34);
    apb(1'b0, OFS_PTR1, 32'h0);
    chk(rd, 32'h134);
    apb(1'b0, OFS_PTR0, 32'h0);
    chk(rd, 32'(PORT_BASE[1] - 12'h5));
    // back-to-back post-increment reads, then a pre-increment read
    core(1'b1, 12'h200, 8'h11);
    core(1'b1, 12'h201, 8'h22);
    apb(1'b1, OFS_PTR2, 32'h200);
    core(1'b0, PORT_BASE[2] - 12'h1, 8'h00);
    core(1'b0, PORT_BASE[2] - 12'h1, 8'h00);
    chk(32'(res_rdata), 32'h22);
    apb(1'b1, OFS_PTR2, 32'h200);
    core(1'b0, PORT_BASE[2] - 12'h3, 8'h00);
    chk(32'(res_rdata), 32'h22);
    complete_run();
  end
endmodule : test_indirect_address_pointer_unit
